// ---- hrc_pkg.sv ----
// Constants, register map and state type for the hub reset and configuration sequencer.
// Assumes a single 40 MHz core clock and a synchronous, active-high hardware reset.

package hrc_pkg;

  localparam int unsigned CLOCK_MHZ = 40;
  localparam int unsigned RECOVER_US = 500;
  localparam int unsigned LOAD_MAX_US = 99500;
  localparam int unsigned POWER_UNIT_US = 2000;
  localparam int unsigned REQ_MAX_US = 5000;
  localparam int unsigned RECOVER_CYC = RECOVER_US * CLOCK_MHZ;
  localparam int unsigned LOAD_MAX_CYC = LOAD_MAX_US * CLOCK_MHZ;
  localparam int unsigned POWER_UNIT_CYC = POWER_UNIT_US * CLOCK_MHZ;
  localparam int unsigned REQ_MAX_CYC = REQ_MAX_US * CLOCK_MHZ;

  localparam logic [7:0] REG_POWER_ON_DELAY = 8'h10;
  localparam logic [7:0] POWER_ON_DELAY_RESET = 8'h00;
  localparam logic [7:0] UNDEFINED_READ = 8'h00;

  localparam logic [1:0] MODE_DEFAULTS = 2'h0;
  localparam logic [1:0] MODE_STRAPS = 2'h1;
  localparam logic [1:0] MODE_EEPROM = 2'h2;
  localparam logic [1:0] MODE_SMBUS = 2'h3;

  localparam logic [6:0] ADDRESS_RESET = 7'h00;
  localparam int STRAP_W = 5;
  localparam int STRAP_AMBER = 0;
  localparam int STRAP_GREEN = 1;
  localparam int STRAP_POL = 2;
  localparam int STRAP_MODE_LO = 3;
  localparam int STRAP_MODE_HI = 4;

  typedef enum logic [1:0] {
    ST_RECOVER,
    ST_LOAD,
    ST_ATTACH,
    ST_RUN
  } hrc_state_e;

endpackage : hrc_pkg

// ---- hrc_timer.sv ----
// One-shot down counter raising a single-cycle pulse after a loaded number of cycles.
// Assumes the caller pulses start once and holds the limit stable while it runs.
`timescale 1ns/1ps
`default_nettype none

module hrc_timer #(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Control.
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] limit,
  // Status.
  output logic running,
  output logic expired
);

  logic [W-1:0] count;

  // The pulse comes limit cycles after start, since count runs from limit-1 to zero.
  always_ff @(posedge clock) begin
    if (rst || stop) begin
      running <= 1'b0;
      count <= '0;
    end else if (start) begin
      running <= 1'b1;
      count <= limit - W'(1);
    end else if (running) begin
      if (count == '0) begin
        running <= 1'b0;
      end else begin
        count <= count - W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || stop || start) begin
      expired <= 1'b0;
    end else begin
      expired <= running && (count == '0);
    end
  end

endmodule : hrc_timer

`default_nettype wire

// ---- hrc_strap_latch.sv ----
// Holds strap pin levels captured on one pulse until the next hardware reset.
// Assumes capture is pulsed once, in the first cycle after reset release.
`timescale 1ns/1ps
`default_nettype none

module hrc_strap_latch #(
  parameter int W = 5
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Capture.
  input wire logic capture,
  input wire logic [W-1:0] pins,
  // Held values.
  output logic [W-1:0] held
);

  always_ff @(posedge clock) begin
    if (rst) begin
      held <= '0;
    end else if (capture) begin
      held <= pins;
    end
  end

endmodule : hrc_strap_latch

`default_nettype wire

// ---- hrc_sequencer.sv ----
// Reset and configuration sequencer for a four-port hub: recovery, configuration load,
// upstream attach, bus-reset effects, port power-on timing and indicator polarity.
// Assumes straps, loader and hub-class strobes are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module hrc_sequencer #(
  parameter int unsigned RECOVER_CYC = hrc_pkg::RECOVER_CYC,
  parameter int unsigned LOAD_MAX_CYC = hrc_pkg::LOAD_MAX_CYC,
  parameter int unsigned POWER_UNIT_CYC = hrc_pkg::POWER_UNIT_CYC,
  parameter int unsigned REQ_MAX_CYC = hrc_pkg::REQ_MAX_CYC,
  parameter int PORTS = 4
) (
  // Clock and hardware reset.
  input wire logic clock,
  input wire logic rst,
  // Strap pins.
  input wire logic [1:0] cfg_mode_strap,
  input wire logic port_power_pol_strap,
  input wire logic self_powered,
  input wire logic eeprom_disable,
  // Configuration register port.
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Configuration loader.
  output logic eeprom_read_start,
  input wire logic eeprom_done,
  input wire logic smbus_load_done,
  output logic load_timeout,
  // Sequencer status.
  output logic osc_pll_enable,
  output logic operational,
  output logic phy_enable,
  output logic upstream_attach,
  // Upstream requests.
  input wire logic usb_bus_reset,
  input wire logic set_address,
  input wire logic [6:0] new_address,
  input wire logic set_configured,
  input wire logic suspend_req,
  input wire logic req_start,
  input wire logic req_done,
  output logic req_deadline,
  output logic [6:0] device_address,
  output logic configured,
  output logic suspended,
  output logic tt_flush,
  // Downstream ports.
  input wire logic [PORTS-1:0] port_power_set,
  input wire logic [PORTS-1:0] port_power_clear,
  output logic [PORTS-1:0] downstream_port_power_enable,
  output logic [PORTS-1:0] port_power_good,
  output logic [PORTS-1:0] downstream_reset,
  // Indicator pins.
  input wire logic led_amber_in,
  input wire logic led_green_in,
  input wire logic led_amber_req,
  input wire logic led_green_req,
  output logic led_amber_out,
  output logic led_amber_oe_n,
  output logic led_green_out,
  output logic led_green_oe_n
);

  hrc_pkg::hrc_state_e state;
  logic rst_q;
  logic capture;
  logic [hrc_pkg::STRAP_W-1:0] straps;
  logic [1:0] mode;
  logic default_mode;
  logic port_pol_high;
  logic amber_active_low;
  logic green_active_low;
  logic [7:0] power_on_delay;
  logic seq_start;
  logic [31:0] seq_limit;
  logic seq_running;
  logic seq_expired;
  logic load_bounded;
  logic req_expired;
  logic [31:0] unit_count;
  logic unit_tick;
  logic [PORTS-1:0] power_on;
  logic [7:0] power_count [PORTS];

  // Capture pulse in the first cycle after hardware reset release.
  always_ff @(posedge clock) begin
    if (rst) begin
      rst_q <= 1'b1;
    end else begin
      rst_q <= 1'b0;
    end
  end

  assign capture = rst_q && !rst;

  hrc_strap_latch #(
    .W(hrc_pkg::STRAP_W)
  ) u_straps (
    .clock(clock),
    .rst(rst),
    .capture(capture),
    .pins({cfg_mode_strap, port_power_pol_strap, led_green_in, led_amber_in}),
    .held(straps)
  );

  assign mode = straps[hrc_pkg::STRAP_MODE_HI:hrc_pkg::STRAP_MODE_LO];
  assign default_mode = (mode == hrc_pkg::MODE_DEFAULTS) || (mode == hrc_pkg::MODE_STRAPS);
  // Only the strap mode overrides port power polarity; other modes keep active-high.
  assign port_pol_high = (mode == hrc_pkg::MODE_STRAPS) ? !straps[hrc_pkg::STRAP_POL] : 1'b1;
  assign amber_active_low = default_mode && straps[hrc_pkg::STRAP_AMBER];
  assign green_active_low = default_mode && straps[hrc_pkg::STRAP_GREEN];

  // Shared timer: recovery interval, then the configuration load bound.
  assign load_bounded = (mode == hrc_pkg::MODE_EEPROM) || !self_powered;
  assign seq_start = capture || (state == hrc_pkg::ST_RECOVER && seq_expired && load_bounded);
  assign seq_limit = capture ? RECOVER_CYC : LOAD_MAX_CYC;

  hrc_timer #(
    .W(32)
  ) u_seq_timer (
    .clock(clock),
    .rst(rst),
    .start(seq_start),
    .stop(1'b0),
    .limit(seq_limit),
    .running(seq_running),
    .expired(seq_expired)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= hrc_pkg::ST_RECOVER;
    end else begin
      unique case (state)
        hrc_pkg::ST_RECOVER: begin
          if (seq_expired) begin
            state <= default_mode ? hrc_pkg::ST_ATTACH : hrc_pkg::ST_LOAD;
          end
        end
        hrc_pkg::ST_LOAD: begin
          if ((mode == hrc_pkg::MODE_EEPROM && (eeprom_done || eeprom_disable)) ||
              (mode == hrc_pkg::MODE_SMBUS && smbus_load_done)) begin
            state <= hrc_pkg::ST_ATTACH;
          end else if (seq_expired) begin
            state <= hrc_pkg::ST_ATTACH;
          end
        end
        hrc_pkg::ST_ATTACH: begin
          state <= hrc_pkg::ST_RUN;
        end
        hrc_pkg::ST_RUN: begin
          state <= hrc_pkg::ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      load_timeout <= 1'b0;
    end else if (state == hrc_pkg::ST_LOAD && seq_expired) begin
      load_timeout <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      eeprom_read_start <= 1'b0;
    end else begin
      eeprom_read_start <= (state == hrc_pkg::ST_RECOVER) && seq_expired &&
                           (mode == hrc_pkg::MODE_EEPROM) && !eeprom_disable;
    end
  end

  // Clocks are held off in reset; PHYs and indicators wait for the recovery interval.
  always_ff @(posedge clock) begin
    if (rst) begin
      osc_pll_enable <= 1'b0;
      operational <= 1'b0;
      upstream_attach <= 1'b0;
    end else begin
      osc_pll_enable <= 1'b1;
      operational <= (state != hrc_pkg::ST_RECOVER) || seq_expired;
      upstream_attach <= (state == hrc_pkg::ST_ATTACH) || (state == hrc_pkg::ST_RUN);
    end
  end

  assign phy_enable = operational;

  // Configuration register port.
  always_ff @(posedge clock) begin
    if (rst) begin
      power_on_delay <= hrc_pkg::POWER_ON_DELAY_RESET;
    end else if (cfg_wr && cfg_addr == hrc_pkg::REG_POWER_ON_DELAY) begin
      power_on_delay <= cfg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_rdata <= hrc_pkg::UNDEFINED_READ;
    end else if (cfg_addr == hrc_pkg::REG_POWER_ON_DELAY) begin
      cfg_rdata <= power_on_delay;
    end else begin
      cfg_rdata <= hrc_pkg::UNDEFINED_READ;
    end
  end

  // Upstream device state, cleared by hardware or bus reset.
  always_ff @(posedge clock) begin
    if (rst || usb_bus_reset) begin
      device_address <= hrc_pkg::ADDRESS_RESET;
      configured <= 1'b0;
      suspended <= 1'b0;
    end else if (state == hrc_pkg::ST_RUN) begin
      if (set_address) begin
        device_address <= new_address;
      end
      if (set_configured) begin
        configured <= 1'b1;
      end
      if (suspend_req) begin
        suspended <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tt_flush <= 1'b0;
    end else begin
      tt_flush <= usb_bus_reset;
    end
  end

  // Bus reset is not forwarded on downstream_reset; downstream ports see it only as port power cleared.
  assign downstream_reset = '0;

  // Request deadline: a pulse when a request has run 5 ms without completing.
  hrc_timer #(
    .W(32)
  ) u_req_timer (
    .clock(clock),
    .rst(rst || usb_bus_reset),
    .start(req_start && state == hrc_pkg::ST_RUN),
    .stop(req_done),
    .limit(REQ_MAX_CYC),
    .running(),
    .expired(req_expired)
  );

  assign req_deadline = req_expired;

  // Power-on time base, one pulse every unit of the delay register.
  always_ff @(posedge clock) begin
    if (rst || unit_tick) begin
      unit_count <= '0;
    end else begin
      unit_count <= unit_count + 32'h1;
    end
  end

  assign unit_tick = (unit_count == POWER_UNIT_CYC - 1);

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_ff @(posedge clock) begin
      if (rst || usb_bus_reset) begin
        power_on[p] <= 1'b0;
        power_count[p] <= 8'h00;
      end else if (port_power_clear[p]) begin
        power_on[p] <= 1'b0;
      end else if (port_power_set[p] && state == hrc_pkg::ST_RUN) begin
        power_on[p] <= 1'b1;
        power_count[p] <= power_on_delay;
      end else if (unit_tick && power_count[p] != 8'h00) begin
        power_count[p] <= power_count[p] - 8'h01;
      end
    end

    always_ff @(posedge clock) begin
      if (rst) begin
        port_power_good[p] <= 1'b0;
        downstream_port_power_enable[p] <= 1'b0;
      end else begin
        port_power_good[p] <= power_on[p] && power_count[p] == 8'h00 && !port_power_set[p];
        downstream_port_power_enable[p] <= power_on[p] ~^ port_pol_high;
      end
    end
  end

  // Indicators: enable low while driving, polarity from the captured strap in the default and strap modes, active-high otherwise.
  always_ff @(posedge clock) begin
    if (rst) begin
      led_amber_oe_n <= 1'b1;
      led_green_oe_n <= 1'b1;
      led_amber_out <= 1'b0;
      led_green_out <= 1'b0;
    end else begin
      led_amber_oe_n <= !operational;
      led_green_oe_n <= !operational;
      led_amber_out <= led_amber_req ^ amber_active_low;
      led_green_out <= led_green_req ^ green_active_low;
    end
  end

endmodule : hrc_sequencer

`default_nettype wire

// ---- hrc_sequencer_sva.sv ----
// Port checker for the hub reset and configuration sequencer.
// Assumes straps stay steady from reset release to the next reset.
`timescale 1ns/1ps
`default_nettype none

module hrc_sequencer_chk #(
  parameter int PORTS = 4
) (
  // Clock, reset and straps.
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] cfg_mode_strap,
  input wire logic eeprom_disable,
  // Watched signals.
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic eeprom_read_start,
  input wire logic osc_pll_enable,
  input wire logic operational,
  input wire logic phy_enable,
  input wire logic upstream_attach,
  input wire logic usb_bus_reset,
  input wire logic [6:0] device_address,
  input wire logic configured,
  input wire logic tt_flush,
  input wire logic [PORTS-1:0] downstream_port_power_enable,
  input wire logic [PORTS-1:0] downstream_reset
);
  default clocking cb @(posedge clock);
  endclocking

  sequence s_write_hold;
    cfg_wr && cfg_addr == 8'h10 ##1 !cfg_wr && cfg_addr == 8'h10;
  endsequence

  a_reset_quiet: assert property (rst |=> !operational && !osc_pll_enable && !upstream_attach
    && downstream_port_power_enable == '0) else $error("outputs active in reset");
  a_phy_tracks: assert property (disable iff (rst) phy_enable == operational)
    else $error("phy enable differs");
  a_undef_zero: assert property (disable iff (rst) cfg_addr != 8'h10 |=> cfg_rdata == 8'h00)
    else $error("undefined read not zero");
  a_reg_readback: assert property (disable iff (rst) s_write_hold |=> cfg_rdata == $past(cfg_wdata, 2))
    else $error("delay register readback");
  a_attach_soon: assert property (disable iff (rst) $rose(operational) && !cfg_mode_strap[1] |-> ##[1:2]
    upstream_attach) else $error("attach late");
  a_eeprom_kick: assert property (disable iff (rst) $rose(operational) |->
    eeprom_read_start == (cfg_mode_strap == 2'h2 && !eeprom_disable)) else $error("eeprom start wrong");
  a_bus_reset_fx: assert property (disable iff (rst) usb_bus_reset |=> device_address == 7'h00
    && !configured && tt_flush) else $error("bus reset effects");
  a_no_forward: assert property (disable iff (rst) downstream_reset == '0)
    else $error("reset forwarded");
endmodule : hrc_sequencer_chk

bind hrc_sequencer hrc_sequencer_chk #(.PORTS(PORTS)) u_chk (.clock, .rst, .cfg_mode_strap, .eeprom_disable,
  .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_rdata, .eeprom_read_start, .osc_pll_enable, .operational, .phy_enable,
  .upstream_attach, .usb_bus_reset, .device_address, .configured, .tt_flush, .downstream_port_power_enable,
  .downstream_reset);

`default_nettype wire

// ---- hrc_loader_model.sv ----
// Far-side loader: serial EEPROM and SMBus host, each ending a load dly+1 cycles after it starts.
// Assumes one eeprom_read_start pulse and one operational rise per reset.
`timescale 1ns/1ps
`default_nettype none

module hrc_loader_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Sequencer side.
  input wire logic eeprom_read_start,
  input wire logic operational,
  output logic eeprom_done = 1'b0,
  output logic smbus_load_done = 1'b0,
  // Bench control.
  input wire logic smbus_en,
  input wire logic [7:0] dly
);
  logic busy = 1'b0, served = 1'b0, from_ee = 1'b0;
  logic [7:0] cnt = 8'h00;

  always @(posedge clock) begin
    eeprom_done <= 1'b0;
    smbus_load_done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
      served <= 1'b0;
    end else if (busy) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        eeprom_done <= from_ee;
        smbus_load_done <= !from_ee;
      end
    end else if (eeprom_read_start || (smbus_en && operational && !served)) begin
      // A bus-powered host keeps dly far below the load bound.
      busy <= 1'b1;
      served <= 1'b1;
      from_ee <= eeprom_read_start;
      cnt <= dly;
    end
  end
endmodule : hrc_loader_model

`default_nettype wire

// ---- hrc_sequencer_tb.sv ----
// Bench for the hub reset and configuration sequencer.
// Assumes shortened counts and the loader model on the far side.
`timescale 1ns/1ps
`default_nettype none

module hrc_sequencer_tb;
  localparam int RC = 20;
  localparam int LM = 200;
  localparam int PU = 10;
  localparam int RQ = 50;
  // Row bits: mode, EEPROM off, self powered, SMBus host on, timeout expected.
  localparam logic [5:0] ROWS [6] = '{6'h00, 6'h10, 6'h20, 6'h28, 6'h32, 6'h31};
  logic clock = 1'b0, rst = 1'b1, port_power_pol_strap = 1'b1, self_powered = 1'b0, eeprom_disable = 1'b0;
  logic cfg_wr = 1'b0, usb_bus_reset = 1'b0, set_address = 1'b0, set_configured = 1'b0, suspend_req = 1'b0;
  logic req_start = 1'b0, req_done = 1'b0, smbus_en = 1'b0, led_amber_in = 1'b1, led_green_in = 1'b0;
  logic led_amber_req = 1'b1, led_green_req = 1'b1, eeprom_done, smbus_load_done, load_timeout, seen;
  logic osc_pll_enable, operational, phy_enable, upstream_attach, req_deadline, configured, suspended, tt_flush;
  logic eeprom_read_start, led_amber_out, led_amber_oe_n, led_green_out, led_green_oe_n;
  logic [1:0] cfg_mode_strap = 2'h0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, dly = 8'h03;
  logic [6:0] new_address = 7'h00, device_address;
  logic [3:0] port_power_set = 4'h0, port_power_clear = 4'h0, downstream_port_power_enable, port_power_good;
  logic [3:0] downstream_reset;
  logic [7:0] undef [3] = '{8'h11, 8'h80, 8'hFF};
  int failures = 0, n_tests = 0, k;

  always #12.5 clock = ~clock;

  hrc_sequencer #(.RECOVER_CYC(RC), .LOAD_MAX_CYC(LM), .POWER_UNIT_CYC(PU), .REQ_MAX_CYC(RQ), .PORTS(4)) u_dut (
    .clock, .rst, .cfg_mode_strap, .port_power_pol_strap, .self_powered, .eeprom_disable, .cfg_wr, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .eeprom_read_start, .eeprom_done, .smbus_load_done, .load_timeout, .osc_pll_enable,
    .operational, .phy_enable, .upstream_attach, .usb_bus_reset, .set_address, .new_address, .set_configured,
    .suspend_req, .req_start, .req_done, .req_deadline, .device_address, .configured, .suspended, .tt_flush,
    .port_power_set, .port_power_clear, .downstream_port_power_enable, .port_power_good, .downstream_reset,
    .led_amber_in, .led_green_in, .led_amber_req, .led_green_req, .led_amber_out, .led_amber_oe_n,
    .led_green_out, .led_green_oe_n);
  hrc_loader_model u_loader (.clock, .rst, .eeprom_read_start, .operational, .eeprom_done, .smbus_load_done,
    .smbus_en, .dly);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic limit(input int lim);
    if (k >= lim) begin
      failures++;
      complete_run();
    end
  endtask : limit

  task automatic wait_attach(input int lim);
    for (k = 0; k < lim && upstream_attach !== 1'b1; k++) tick(1);
    limit(lim);
  endtask : wait_attach

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    {cfg_wr, cfg_addr, cfg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    cfg_addr <= a;
    tick(2);
    chk(cfg_rdata, e);
  endtask : rd

  task automatic strobe(input logic s, input logic d);
    @(posedge clock);
    {req_start, req_done} <= {s, d};
    @(posedge clock);
    {req_start, req_done} <= 2'b00;
    tick(0);
  endtask : strobe

  task automatic do_reset(input logic [5:0] r);
    @(posedge clock);
    rst <= 1'b1;
    {cfg_mode_strap, eeprom_disable, self_powered, smbus_en} <= r[5:1];
    {led_amber_in, led_green_in} <= 2'b10;
    dly <= r[5:4] == 2'h2 ? 8'h40 : 8'h03;
    tick(2);
    chk({operational, osc_pll_enable, led_amber_oe_n, led_green_oe_n, downstream_port_power_enable}, 8'h30);
    @(posedge clock);
    rst <= 1'b0;
    for (k = 0; k < RC + 5 && operational !== 1'b1; k++) tick(1);
    limit(RC + 5);
    chk(8'(k), 8'(RC + 2));
    chk({7'h00, eeprom_read_start}, {7'h00, r[5:4] == 2'h2 && !r[3]});
  endtask : do_reset

  initial begin
    foreach (ROWS[i]) begin
      do_reset(ROWS[i]);
      wait_attach(LM + 9);
      if (!ROWS[i][5]) begin
        chk(8'(k), 8'h01);
      end
      chk({7'h00, load_timeout}, {7'h00, ROWS[i][0]});
      @(posedge clock);
      {led_amber_in, led_green_in} <= 2'b01;
      tick(3);
      chk({4'h0, led_amber_out, led_amber_oe_n, led_green_out, led_green_oe_n}, {4'h0, ROWS[i][5], 3'b010});
      chk({4'h0, downstream_port_power_enable}, {4'h0, {4{ROWS[i][5:4] == 2'h1}}});
    end
    do_reset(6'h00);
    wait_attach(9);
    rd(8'h10, 8'h00);
    foreach (undef[i]) begin
      wr(undef[i], 8'hFF);
      rd(undef[i], 8'h00);
    end
    rd(8'h10, 8'h00);
    wr(8'h10, 8'h03);
    rd(8'h10, 8'h03);
    @(posedge clock);
    port_power_set <= 4'h1;
    @(posedge clock);
    port_power_set <= 4'h0;
    tick(0);
    for (k = 0; k < 60 && port_power_good[0] !== 1'b1; k++) tick(1);
    limit(60);
    chk({4'h0, downstream_port_power_enable}, 8'h01);
    chk({7'h00, k >= 2 * PU && k <= 4 * PU + 2}, 8'h01);
    // Port 1 is powered and then cleared; the enable follows power state one edge later.
    @(posedge clock);
    port_power_set <= 4'h2;
    @(posedge clock);
    {port_power_set, port_power_clear} <= 8'h02;
    @(posedge clock);
    port_power_clear <= 4'h0;
    tick(0);
    chk({4'h0, downstream_port_power_enable}, 8'h03);
    tick(1);
    chk({4'h0, downstream_port_power_enable}, 8'h01);
    @(posedge clock);
    {set_address, set_configured, suspend_req, new_address} <= {3'b111, 7'h2A};
    @(posedge clock);
    {set_address, set_configured, suspend_req} <= 3'b000;
    tick(40); // The host waits after attach before a bus reset.
    chk({configured, device_address}, 8'hAA);
    chk({7'h00, suspended}, 8'h01);
    @(posedge clock);
    usb_bus_reset <= 1'b1;
    @(posedge clock);
    usb_bus_reset <= 1'b0;
    tick(0);
    chk({configured, device_address}, 8'h00);
    chk({suspended, tt_flush, 6'h00}, 8'h40);
    tick(1);
    chk({4'h0, downstream_port_power_enable}, 8'h00);
    chk({4'h0, downstream_reset}, 8'h00);
    strobe(1'b1, 1'b0);
    for (k = 1; k < RQ + 9 && req_deadline !== 1'b1; k++) tick(1);
    limit(RQ + 9);
    chk({7'h00, k >= RQ && k <= RQ + 2}, 8'h01);
    strobe(1'b1, 1'b0);
    tick(10);
    strobe(1'b0, 1'b1);
    seen = 1'b0;
    repeat (RQ + 5) begin
      tick(1);
      seen |= req_deadline;
    end
    chk({7'h00, seen}, 8'h00);
    do_reset(6'h34);
    seen = 1'b0;
    repeat (LM + 20) begin
      tick(1);
      seen |= upstream_attach | load_timeout;
    end
    chk({7'h00, seen}, 8'h00);
    @(posedge clock);
    smbus_en <= 1'b1;
    wait_attach(20);
    complete_run();
  end
endmodule : hrc_sequencer_tb

`default_nettype wire
